// ---- src/ccsp_cfg.svh ----
`ifndef CCSP_CFG_SVH
`define CCSP_CFG_SVH

`define CCSP_ADDR_W            12
`define CCSP_OFF_CFG_ONE       12'h004
`define CCSP_CFG_RESET         32'h0000_0000
`define CCSP_CFG_WMASK         32'h073f_47f3

`define CCSP_SYS_SEL_LSB       0
`define CCSP_SYS_STS_LSB       2
`define CCSP_BUS_DIV_LSB       4
`define CCSP_PER_DIV_LSB       8
`define CCSP_CONV_DIV_BIT      14
`define CCSP_LOOP_SRC_BIT      16
`define CCSP_LOOP_EXT_BIT      17
`define CCSP_LOOP_MUL_LSB      18
`define CCSP_CLK_OUT_LSB       24

`define CCSP_SRC_RC            2'h0
`define CCSP_SRC_EXT           2'h1
`define CCSP_SRC_LOOP          2'h2

`define CCSP_OUT_NONE          3'h0
`define CCSP_OUT_RC14          3'h3
`define CCSP_OUT_SYS           3'h4
`define CCSP_OUT_RC            3'h5
`define CCSP_OUT_EXT           3'h6

`define CCSP_SWITCH_CYCLES     2'h2
`define CCSP_LOOP_MUL_MAX      5'h10

`define CCSP_RESP_OKAY         2'h0
`define CCSP_RESP_SLVERR       2'h2

`endif

// ---- src/ccsp_pkg.sv ----
package ccsp_pkg;

   typedef enum logic [2:0] {
      CCSP_SW_IDLE  = 3'b001,
      CCSP_SW_DRAIN = 3'b010,
      CCSP_SW_TAKE  = 3'b100
   } ccsp_sw_state_t;

   typedef struct packed {
      logic [3:0] div_log2;
      logic [4:0] mul_factor;
   } ccsp_decode_t;

endpackage

// ---- src/ccsp_div_if.sv ----
`timescale 1ns/1ps

interface ccsp_div_if;
   logic [3:0] bus_code;
   logic [2:0] per_code;
   logic [3:0] mul_code;
   logic [3:0] bus_log2;
   logic [3:0] per_log2;
   logic [4:0] mul_factor;

   modport dec (input bus_code, per_code, mul_code, output bus_log2, per_log2, mul_factor);
   modport use_ (output bus_code, per_code, mul_code, input bus_log2, per_log2, mul_factor);
endinterface

// ---- src/ccsp_div_decode.sv ----
`timescale 1ns/1ps
`include "ccsp_cfg.svh"

module ccsp_div_decode (
   ccsp_div_if.dec dif
);

   always_comb begin
      if (!dif.bus_code[3]) begin
         dif.bus_log2 = 4'h0;
      end else if (!dif.bus_code[2]) begin
         dif.bus_log2 = {2'h0, dif.bus_code[1:0]} + 4'h1;
      end else begin
         dif.bus_log2 = {2'h0, dif.bus_code[1:0]} + 4'h6;
      end
      if (!dif.per_code[2]) begin
         dif.per_log2 = 4'h0;
      end else begin
         dif.per_log2 = {2'h0, dif.per_code[1:0]} + 4'h1;
      end
      if (dif.mul_code >= 4'he) begin
         dif.mul_factor = `CCSP_LOOP_MUL_MAX;
      end else begin
         dif.mul_factor = {1'b0, dif.mul_code} + 5'h02;
      end
   end

endmodule // ccsp_div_decode

// ---- src/ccsp_clock_config.sv ----
`timescale 1ns/1ps
`include "ccsp_cfg.svh"
// Operation
// - select codes 00 rc, 01 external, 10 loop; 11 reserved
// - status field shows source really in use; never 11
// - bus divider: top bit 0 none; 1000-1011 /2..16; 1100-1111 /64..512
// - peripheral divider: top bit 0 none; 100-111 divide by 2,4,8,16
// - loop source bit changes only while loop disabled
// - loop fed by rc/2 when bit 0, prescaled external when 1
// - multiplier code n gives n+2; 1110 and 1111 give 16
// - multiplier writable only while loop disabled
// - clock out: 000 none, 011 rc14, 100 sys, 101 rc, 110 ext
// - zero wait normally, one or two during a clock switch
// - every field reads zero after reset
// - word, half and byte access; writes touch addressed lanes only
// - bit 17 mirrors external loop prescale bit of config two
// - loop enable cleared on low-power entry, even while feeding system; clear request refused while loop in use

module ccsp_clock_config (
   input  wire logic                    clk_sys_i,
   input  wire logic                    rst_b_i,
   input  wire logic [`CCSP_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [`CCSP_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   input  wire logic                    lowpower_wake_i,
   input  wire logic                    lowpower_entry_i,
   input  wire logic                    ext_clock_fail_i,
   input  wire logic                    clock_security_en_i,
   input  wire logic                    loop_enable_set_i,
   input  wire logic                    loop_enable_clr_i,
   input  wire logic                    cfg_two_ext_write_i,
   input  wire logic                    cfg_two_ext_data_i,
   output logic                         loop_enable_o,
   output logic                         loop_ext_prescale_o,
   output logic [1:0]                   sys_source_o,
   output logic [3:0]                   bus_div_log2_o,
   output logic [3:0]                   periph_div_log2_o,
   output logic                         loop_source_o,
   output logic [4:0]                   loop_mul_factor_o,
   output logic [2:0]                   clock_out_select_o,
   output logic                         converter_div_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic                        aw_held;
      logic [`CCSP_ADDR_W-1:0]     aw_addr;
      logic                        w_held;
      logic [31:0]                 w_data;
      logic [3:0]                  w_strb;
      logic                        bvalid;
      logic [1:0]                  bresp;
      logic                        ar_held;
      logic [`CCSP_ADDR_W-1:0]     ar_addr;
      logic                        rvalid;
      logic [31:0]                 rdata;
      logic [1:0]                  rresp;
      logic [1:0]                  sel;
      logic [1:0]                  sts;
      logic [3:0]                  bus_div;
      logic [2:0]                  per_div;
      logic                        conv_div;
      logic                        loop_src;
      logic                        loop_ext;
      logic [3:0]                  loop_mul;
      logic [2:0]                  out_sel;
      logic                        loop_en;
      ccsp_pkg::ccsp_sw_state_t    sw_state;
      logic [1:0]                  sw_target;
      logic [1:0]                  sw_count;
      logic [3:0]                  bus_log2;
      logic [3:0]                  per_log2;
      logic [4:0]                  mul_factor;
      logic [2:0]                  out_code;
   } ccsp_state_t;

   ccsp_state_t st;
   ccsp_state_t next_st;

   ccsp_div_if dif ();

   ccsp_div_decode u_decode (
      .dif (dif.dec)
   );

   assign dif.bus_code = st.bus_div;
   assign dif.per_code = st.per_div;
   assign dif.mul_code = st.loop_mul;

   ////////////////////////////////////////////////////////////////////////////////
   // read image

   logic [31:0] cfg_image;

   always_comb begin
      cfg_image = 32'h0000_0000;
      cfg_image[`CCSP_SYS_SEL_LSB +: 2]  = st.sel;
      cfg_image[`CCSP_SYS_STS_LSB +: 2]  = st.sts;
      cfg_image[`CCSP_BUS_DIV_LSB +: 4]  = st.bus_div;
      cfg_image[`CCSP_PER_DIV_LSB +: 3]  = st.per_div;
      cfg_image[`CCSP_CONV_DIV_BIT]      = st.conv_div;
      cfg_image[`CCSP_LOOP_SRC_BIT]      = st.loop_src;
      cfg_image[`CCSP_LOOP_EXT_BIT]      = st.loop_ext;
      cfg_image[`CCSP_LOOP_MUL_LSB +: 4] = st.loop_mul;
      cfg_image[`CCSP_CLK_OUT_LSB +: 3]  = st.out_sel;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   logic [31:0] lane_mask;
   logic [31:0] merged;
   logic        do_write;
   logic        hit_w;
   logic        force_rc;
   logic        switching;
   logic        loop_in_use;

   always_comb begin
      next_st   = st;
      lane_mask = 32'h0000_0000;
      merged    = cfg_image;
      do_write  = 1'b0;
      hit_w     = 1'b0;
      // secured failure only matters while external feeds the system clock, directly or through the loop
      force_rc  = lowpower_wake_i
                | (ext_clock_fail_i & clock_security_en_i
                   & ((st.sts == `CCSP_SRC_EXT)
                      | (st.sts == `CCSP_SRC_LOOP & st.loop_src)));
      switching = (st.sw_state != ccsp_pkg::CCSP_SW_IDLE);
      loop_in_use = (st.sel == `CCSP_SRC_LOOP) | (st.sts == `CCSP_SRC_LOOP)
                  | (switching & st.sw_target == `CCSP_SRC_LOOP);

      // write channel capture, either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_st.w_held = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
      end
      // writes stall while a switch is under way
      if (st.aw_held && st.w_held && !st.bvalid && !switching) begin
         do_write        = 1'b1;
         hit_w           = (st.aw_addr[`CCSP_ADDR_W-1:2] == 10'(`CCSP_OFF_CFG_ONE >> 2));
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = hit_w ? `CCSP_RESP_OKAY : `CCSP_RESP_SLVERR;
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end

      if (do_write && hit_w) begin
         for (int i = 0; i < 4; i++) begin
            lane_mask[i*8 +: 8] = {8{st.w_strb[i]}};
         end
         lane_mask = lane_mask & `CCSP_CFG_WMASK;
         merged    = (cfg_image & ~lane_mask) | (st.w_data & lane_mask);
         next_st.sel      = merged[`CCSP_SYS_SEL_LSB +: 2];
         next_st.bus_div  = merged[`CCSP_BUS_DIV_LSB +: 4];
         next_st.per_div  = merged[`CCSP_PER_DIV_LSB +: 3];
         next_st.conv_div = merged[`CCSP_CONV_DIV_BIT];
         next_st.loop_ext = merged[`CCSP_LOOP_EXT_BIT];
         next_st.out_sel  = merged[`CCSP_CLK_OUT_LSB +: 3];
         if (!st.loop_en) begin
            next_st.loop_src = merged[`CCSP_LOOP_SRC_BIT];
            next_st.loop_mul = merged[`CCSP_LOOP_MUL_LSB +: 4];
         end
      end
      if (cfg_two_ext_write_i) begin
         next_st.loop_ext = cfg_two_ext_data_i;
      end

      // reserved select code keeps the current source
      if (next_st.sel == 2'h3) begin
         next_st.sel = st.sel;
      end
      if (force_rc) begin
         next_st.sel = `CCSP_SRC_RC;
      end

      // loop enable from the control register side
      if (loop_enable_set_i) begin
         next_st.loop_en = 1'b1;
      end
      if (loop_enable_clr_i && !loop_in_use) begin
         next_st.loop_en = 1'b0;
      end
      if (lowpower_entry_i) begin
         next_st.loop_en = 1'b0;
      end

      // drain old source, then take the new one before status moves
      unique case (st.sw_state)
         ccsp_pkg::CCSP_SW_IDLE: begin
            if (next_st.sel != st.sts) begin
               next_st.sw_state  = ccsp_pkg::CCSP_SW_DRAIN;
               next_st.sw_target = next_st.sel;
               next_st.sw_count  = 2'h1;
            end
         end
         ccsp_pkg::CCSP_SW_DRAIN: begin
            if (st.sw_count == `CCSP_SWITCH_CYCLES - 2'h1) begin
               next_st.sw_state = ccsp_pkg::CCSP_SW_TAKE;
            end else begin
               next_st.sw_count = st.sw_count + 2'h1;
            end
         end
         ccsp_pkg::CCSP_SW_TAKE: begin
            next_st.sts      = st.sw_target;
            next_st.sw_state = ccsp_pkg::CCSP_SW_IDLE;
         end
         default: begin
            next_st.sw_state = ccsp_pkg::CCSP_SW_IDLE;
         end
      endcase

      // read path, held off during a switch
      if (s_axi_arvalid && s_axi_arready) begin
         next_st.ar_held = 1'b1;
         next_st.ar_addr = s_axi_araddr;
      end
      if (st.ar_held && !st.rvalid && !switching) begin
         next_st.ar_held = 1'b0;
         next_st.rvalid  = 1'b1;
         if (st.ar_addr[`CCSP_ADDR_W-1:2] == 10'(`CCSP_OFF_CFG_ONE >> 2)) begin
            next_st.rdata = cfg_image;
            next_st.rresp = `CCSP_RESP_OKAY;
         end else begin
            next_st.rdata = 32'h0000_0000;
            next_st.rresp = `CCSP_RESP_SLVERR;
         end
      end
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end

      next_st.bus_log2   = dif.bus_log2;
      next_st.per_log2   = dif.per_log2;
      next_st.mul_factor = dif.mul_factor;
      // reserved codes drive no clock; registered so the pin comes from a flop
      if (st.out_sel == 3'h1 || st.out_sel == 3'h2 || st.out_sel == 3'h7) begin
         next_st.out_code = `CCSP_OUT_NONE;
      end else begin
         next_st.out_code = st.out_sel;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         st          <= '0;
         st.sw_state <= ccsp_pkg::CCSP_SW_IDLE;
         st.mul_factor <= 5'h02;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   assign s_axi_awready       = !st.aw_held;
   assign s_axi_wready        = !st.w_held;
   assign s_axi_bvalid        = st.bvalid;
   assign s_axi_bresp         = st.bresp;
   assign s_axi_arready       = !st.ar_held;
   assign s_axi_rvalid        = st.rvalid;
   assign s_axi_rdata         = st.rdata;
   assign s_axi_rresp         = st.rresp;
   assign loop_enable_o       = st.loop_en;
   assign loop_ext_prescale_o = st.loop_ext;
   assign sys_source_o        = st.sts;
   assign bus_div_log2_o      = st.bus_log2;
   assign periph_div_log2_o   = st.per_log2;
   assign loop_source_o       = st.loop_src;
   assign loop_mul_factor_o   = st.mul_factor;
   assign clock_out_select_o  = st.out_code;
   assign converter_div_o     = st.conv_div;

endmodule // ccsp_clock_config

// ---- test/ccsp_clock_config_props.sv ----
`timescale 1ns/1ps
module ccsp_clock_config_props (
   input wire logic        clk_sys_i,
   input wire logic        rst_b_i,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        lowpower_wake_i,
   input wire logic        lowpower_entry_i,
   input wire logic        loop_enable_clr_i,
   input wire logic        loop_enable_o,
   input wire logic [1:0]  sys_source_o,
   input wire logic [3:0]  bus_div_log2_o,
   input wire logic        loop_source_o,
   input wire logic [4:0]  loop_mul_factor_o,
   input wire logic [2:0]  clock_out_select_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   a_status_not_three: assert property (sys_source_o != 2'h3)
      else $error("status shows code three");
   a_read_reserved: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hf8c0_b800) == 0)
      else $error("reserved bits read nonzero");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:5] s_axi_bvalid)
      else $error("write answer late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:5] s_axi_rvalid)
      else $error("read answer late");
   a_mul_range: assert property (loop_mul_factor_o >= 5'h2 && loop_mul_factor_o <= 5'h10)
      else $error("multiplier out of range");
   a_bus_div_set: assert property (bus_div_log2_o != 4'h5 && bus_div_log2_o <= 4'h9)
      else $error("bus division not allowed");
   a_src_locked: assert property ($past(loop_enable_o) && $past(loop_enable_o, 2)
      |-> $stable(loop_source_o))
      else $error("loop source changed while enabled");
   a_mul_locked: assert property ($past(loop_enable_o) && $past(loop_enable_o, 2)
      |-> $stable(loop_mul_factor_o))
      else $error("multiplier changed while enabled");
   a_entry_clears: assert property (lowpower_entry_i |=> !loop_enable_o)
      else $error("loop enable kept on entry");
   a_clear_refused: assert property (loop_enable_o && loop_enable_clr_i && !lowpower_entry_i
      && sys_source_o == 2'h2 |=> loop_enable_o)
      else $error("loop enable cleared while in use");
   a_wake_forces_rc: assert property (lowpower_wake_i |-> ##[1:8] sys_source_o == 2'h0)
      else $error("wake did not force rc");
   a_out_reserved: assert property (!(clock_out_select_o inside {3'h1, 3'h2, 3'h7}))
      else $error("reserved clock out code driven");
endmodule // ccsp_clock_config_props
bind ccsp_clock_config ccsp_clock_config_props ccsp_clock_config_props_i (.clk_sys_i, .rst_b_i,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .lowpower_wake_i, .lowpower_entry_i,
   .loop_enable_clr_i, .loop_enable_o, .sys_source_o, .bus_div_log2_o, .loop_source_o,
   .loop_mul_factor_o, .clock_out_select_o);

// ---- test/tb_ccsp_clock_config.sv ----
`timescale 1ns/1ps
`include "ccsp_cfg.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin miscompares++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb_ccsp_clock_config;
   localparam logic [11:0] OFF = `CCSP_OFF_CFG_ONE;
   logic        clk_sys_i, rst_b_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, clock_security_en_i, cfg_two_ext_data_i, loop_enable_o;
   logic        loop_ext_prescale_o, loop_source_o, converter_div_o;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   logic [3:0]  s_axi_wstrb, bus_div_log2_o, periph_div_log2_o, c;
   logic [1:0]  s_axi_bresp, s_axi_rresp, sys_source_o, brsp, rrsp;
   logic [4:0]  loop_mul_factor_o;
   logic [2:0]  clock_out_select_o, p;
   logic [5:0]  ev;
   int          miscompares = 0;
   int          checked = 0;
   ccsp_clock_config ccsp_clock_config_i (.clk_sys_i, .rst_b_i, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lowpower_wake_i(ev[0]),
      .lowpower_entry_i(ev[1]), .ext_clock_fail_i(ev[2]), .clock_security_en_i,
      .loop_enable_set_i(ev[3]), .loop_enable_clr_i(ev[4]), .cfg_two_ext_write_i(ev[5]),
      .cfg_two_ext_data_i, .loop_enable_o, .loop_ext_prescale_o, .sys_source_o, .bus_div_log2_o,
      .periph_div_log2_o, .loop_source_o, .loop_mul_factor_o, .clock_out_select_o,
      .converter_div_o);
   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge clk_sys_i);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready}
         <= {a, d, s, 3'b111};
      for (n = 0; n < 40; n++) begin
         @(posedge clk_sys_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      brsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 40) miscompares++;
   endtask
   task automatic rd(input logic [11:0] a);
      int n;
      @(posedge clk_sys_i);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
      for (n = 0; n < 40; n++) begin
         @(posedge clk_sys_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      {rdat, rrsp} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
      if (n == 40) miscompares++;
   endtask
   // one-cycle event, then room for the clock switch to settle
   task automatic pulse(input int b);
      @(posedge clk_sys_i);
      ev[b] <= 1'b1;
      @(posedge clk_sys_i);
      ev[b] <= 1'b0;
      repeat (6) @(posedge clk_sys_i);
   endtask
   task automatic report_and_stop;
      if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      #500000;
      miscompares++;
      report_and_stop;
   end
   initial begin
      {rst_b_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, ev} = '0;
      {clock_security_en_i, cfg_two_ext_data_i} = '0;
      repeat (2) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      rd(OFF);
      `CHK("reset value", 32'h0, rdat)
      `CHK("reset mul", 5'h2, loop_mul_factor_o)
      wr(OFF, 32'hffff_ffff, 4'hf);
      rd(OFF);
      `CHK("all ones", 32'h073f_47f0, rdat)
      for (int i = 0; i < 4; i++) begin
         wr(OFF, 32'h0, 4'hf);
         wr(OFF, 32'hffff_ffff, 4'(1 << i));
         rd(OFF);
         `CHK("lane write", 32'h073f_47f0 & (32'hff << (8 * i)), rdat)
      end
      for (int i = 0; i < 16; i++) begin
         c = 4'(i);
         p = c[2:0];
         wr(OFF, {5'h0, p, 2'h0, c, 7'h0, p, c, 4'h0}, 4'hf); // prefetch lives outside
         repeat (2) @(posedge clk_sys_i);
         `CHK("bus div", (c < 8) ? 4'h0 : (c < 12) ? 4'(c - 7) : 4'(c - 6), bus_div_log2_o)
         `CHK("per div", (p < 4) ? 4'h0 : 4'(p - 3), periph_div_log2_o)
         `CHK("mul", (c > 13) ? 5'h10 : 5'(c + 2), loop_mul_factor_o)
         `CHK("clk out", (p inside {1, 2, 7}) ? 3'h0 : p, clock_out_select_o)
      end
      wr(OFF, 32'h1, 4'hf);
      rd(OFF);
      repeat (4) @(posedge clk_sys_i);
      `CHK("status", 2'h1, sys_source_o)
      rd(OFF);
      `CHK("status read", 4'h5, rdat[3:0])
      wr(OFF, 32'h3, 4'h1);
      rd(OFF);
      `CHK("select kept", 2'h1, rdat[1:0])
      clock_security_en_i <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         wr(OFF, 32'h1, 4'hf);
         repeat (5) @(posedge clk_sys_i);
         pulse(k * 2);
         rd(OFF);
         `CHK("forced rc", 4'h0, rdat[3:0])
      end
      wr(OFF, 32'h0001_0000, 4'hf);
      pulse(3);
      wr(OFF, 32'h003c_0002, 4'hf); // loop stays at times two
      repeat (5) @(posedge clk_sys_i);
      rd(OFF);
      `CHK("locked fields", 32'h0001_000a, rdat)
      `CHK("loop src", 1'b1, loop_source_o)
      pulse(4);
      `CHK("clear refused", 1'b1, loop_enable_o)
      wr(OFF, 32'h0001_0000, 4'hf);
      repeat (5) @(posedge clk_sys_i);
      pulse(3);
      pulse(1);
      `CHK("entry clears", 1'b0, loop_enable_o)
      cfg_two_ext_data_i <= 1'b1;
      pulse(5);
      rd(OFF);
      `CHK("mirror bit", 2'h3, {rdat[17], loop_ext_prescale_o})
      wr(12'h008, 32'hffff_ffff, 4'hf);
      `CHK("unmapped write", 2'h2, brsp)
      rd(12'h008);
      `CHK("unmapped read", 34'h2, {rdat, rrsp})
      report_and_stop;
   end
endmodule // tb_ccsp_clock_config
